// ### dv/host_kbd_model.sv
`timescale 1ns/1ns
// ****
// Host keyboard channel
// ****
module host_kbd_model (
  output logic kbd_load,
  output logic kbd_clock,
  input  logic kbd_inhibit,
  input  logic kbd_data
);
  logic [7:0] rx_q[$]; // Bytes seen, oldest first
  logic [7:0] sh;      // Byte being assembled

  // Load pulse, then settle time for the sync flops
  task automatic pulse_load();
    kbd_load = 1'b1;
    #48;
    kbd_load = 1'b0;
    #100;
  endtask : pulse_load

  // One character: b7 first, then b0..b6
  task automatic take_byte();
    pulse_load();
    for (int k = 0; k < 8; k++) begin
      kbd_clock = 1'b1;
      #24;
      kbd_clock = 1'b0;
      #24;
      // Sampled late in the period, well after the flop moved
      sh[k == 0 ? 7 : k - 1] = kbd_data;
    end
    rx_q.push_back(sh);
    #100;
  endtask : take_byte

  // Loads at character rate; clock only runs within a frame
  initial begin
    kbd_load = 1'b0;
    kbd_clock = 1'b0;
    forever begin
      pulse_load();
      while (kbd_inhibit === 1'b1) begin
        take_byte();
      end
    end
  end
endmodule : host_kbd_model

// ### dv/mag_stripe_card_reader_link_bench.sv
`timescale 1ns/1ns
`include "mag_regs.svh"
module mag_stripe_card_reader_link_bench;
  import mag_pkg::*;
  // ****
  // Signals
  // ****
  logic        clock, nrst, stripe_in;
  wb_req_t     wb_i;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, kbd_load, kbd_clock, kbd_inhibit, kbd_data;
  logic        reader_active_n, bank_format_n, error_led, busy_led;
  logic [2:0]  head_sel_n;
  int          failures, checks, cycles;

  // Short timeout and lamp time keep the run small
  mag_stripe_card_reader_link #(.TIMEOUT(24'd2000), .CELL_MIN(24'd4), .ERR_CYCLES(200))
    mag_stripe_card_reader_link_i (
    .clock(clock), .nrst(nrst), .wb_i(wb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .head_sel_n(head_sel_n), .stripe_in(stripe_in), .kbd_load(kbd_load),
    .kbd_clock(kbd_clock), .kbd_inhibit(kbd_inhibit), .kbd_data(kbd_data),
    .reader_active_n(reader_active_n), .bank_format_n(bank_format_n),
    .error_led(error_led), .busy_led(busy_led));

  host_kbd_model host_kbd_model_i (
    .kbd_load(kbd_load), .kbd_clock(kbd_clock), .kbd_inhibit(kbd_inhibit),
    .kbd_data(kbd_data));

  // 4 ns clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 25000) begin
      failures++;
      test_done();
    end
  end

  task test_done();
    if (failures == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // ****
  // Classic Wishbone single cycle
  // ****
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clock);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    @(posedge clock);
    while (wb_ack_o !== 1'b1) @(posedge clock);
    rd = wb_dat_o;
    wb_i <= '0;
  endtask : wb

  // Biphase cells of 40 cycles, LSB first
  task bits(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      stripe_in <= ~stripe_in;
      repeat (20) @(posedge clock);
      // Mid-cell edge marks a one
      if (v[i]) stripe_in <= ~stripe_in;
      repeat (20) @(posedge clock);
    end
  endtask : bits

  // Card of w-bit chars: leading zeros, sentinel, one char, optional end and check char
  task card(input int w, input logic [6:0] ss, input logic [6:0] d, input logic [6:0] lrc,
            input logic with_end);
    bits(32'h0, 26);
    bits(32'(ss), w);
    bits(32'(d), w);
    if (with_end) begin
      bits(32'(w == 5 ? `BANK_ES : `AIR_ES), w);
      bits(32'(lrc), w);
      bits(32'h0, 4);
    end
  endtask : card

  // Whole message as the host sees it, first byte in the top bits
  task msg(input logic [47:0] e);
    while (host_kbd_model_i.rx_q.size() < 1) @(posedge clock);
    chk("kbd_inhibit", 1, kbd_inhibit);
    while (host_kbd_model_i.rx_q.size() < 6) @(posedge clock);
    for (int i = 0; i < 6; i++) begin
      chk("kbd_byte", e[47 - 8 * i -: 8], host_kbd_model_i.rx_q[i]);
    end
    repeat (60) @(posedge clock);
    chk("kbd_bytes", 6, host_kbd_model_i.rx_q.size());
    chk("kbd_inhibit", 0, kbd_inhibit);
    chk("reader_active_n", 1, reader_active_n);
    chk("busy_led", 0, busy_led);
    host_kbd_model_i.rx_q.delete();
  endtask : msg

  // ****
  // Main sequence
  // ****
  initial begin
    nrst = 1'b0;
    wb_i = '0;
    head_sel_n = 3'b110;
    stripe_in = 1'b0;
    failures = 0;
    checks = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    wb(1'b0, `CTRL_OFS, 32'h0);
    chk("ctrl_enable", 1, rd & 32'h1);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 0, rd);
    repeat (10) @(posedge clock);
    chk("bank_format_n", 0, bank_format_n);
    // Clean bank card
    card(5, `BANK_SS, 7'h01, 7'h15, 1'b1);
    chk("reader_active_n", 0, reader_active_n);
    chk("busy_led", 1, busy_led);
    msg({`SOD_CHAR, `TYPE_CHAR, 32'h0b01_1f15});
    chk("error_led", 0, error_led);
    // Bad parity: lamp lit, message still sent; cleared about 35 cycles before the 200-cycle lamp time runs out
    card(5, `BANK_SS, 7'h11, 7'h15, 1'b1);
    repeat (2) @(posedge clock);
    chk("error_led", 1, error_led);
    wb(1'b0, `STAT_OFS, 32'h0);
    chk("parity_sticky", 32'h4, rd & 32'h4);
    wb(1'b1, `STAT_OFS, 32'h4);
    wb(1'b1, `CTRL_OFS, 32'h3);
    wb(1'b0, `STAT_OFS, 32'h0);
    chk("status_clear", 0, rd & 32'h6);
    chk("error_led", 0, error_led);
    msg({`SOD_CHAR, `TYPE_CHAR, 32'h0b11_1f15});
    // No end sentinel: read dropped
    card(5, `BANK_SS, 7'h01, 7'h15, 1'b0);
    repeat (2060) @(posedge clock);
    chk("error_led", 1, error_led);
    chk("reader_active_n", 1, reader_active_n);
    chk("kbd_bytes", 0, host_kbd_model_i.rx_q.size());
    // Airline head: seven-bit characters and their own repacking
    wb(1'b1, `CTRL_OFS, 32'h3);
    head_sel_n <= 3'b101;
    repeat (10) @(posedge clock);
    chk("bank_format_n", 1, bank_format_n);
    card(7, `AIR_SS, 7'h01, 7'h5b, 1'b1);
    wb(1'b0, `STAT_OFS, 32'h0);
    chk("status_airline", 32'h9, rd & 32'h9);
    msg({`SOD_CHAR, `TYPE_CHAR, 32'h1501_2f3b});
    test_done();
  end
endmodule : mag_stripe_card_reader_link_bench

// ### src/mag_pkg.sv
package mag_pkg;
  // Reader sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_SKIP, ST_HUNT, ST_STORE, ST_LRC, ST_CHECK, ST_WAIT, ST_LOCK, ST_SHIFT
  } rd_state_t;
  // Classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;
endpackage : mag_pkg

// ### src/mag_regs.svh
`ifndef MAG_REGS_SVH
`define MAG_REGS_SVH
// ****************************************
// Register map, byte addresses
// ****************************************
`define CTRL_OFS     8'h00
`define STAT_OFS     8'h04
`define CELL_OFS     8'h08
`define CTRL_EN_BIT  0
`define CTRL_CLR_BIT 1
`define STAT_PE_BIT  2
`define CTRL_RST     1'b1
// ****************************************
// Message characters and formats
// ****************************************
`define SOD_CHAR     8'h21
`define TYPE_CHAR    8'h10
`define BANK_SS      7'h0b
`define BANK_ES      7'h1f
`define AIR_SS       7'h45
`define AIR_ES       7'h1f
`define BANK_LAST    3'd4
`define AIR_LAST     3'd6
`define BANK_MAX     7'd37
`define AIR_MAX      7'd76
// ****************************************
// Timing
// ****************************************
`define SKIP_EDGES   5'd16
`define ZERO_RUN     4'd8
`define CLK_MHZ      250
`define ERR_TIME_MS  2000
`define ERR_CYC      (`ERR_TIME_MS * 1000 * `CLK_MHZ)
`define SYNC_RST     6'h38
`endif

// ### src/mag_stripe_card_reader_link.sv
`timescale 1ns/1ns
`include "mag_regs.svh"
// Function
// - Head counts as selected when its level low
// - Three head inputs, one stripe input, event per transition
// - Inhibit keyboard from first load until message sent
// - Output flop captures data each keyboard clock
// - Short interval below three quarters means one
// - Skip sixteen transitions, sync on leading zeros
// - After start sentinel store characters until end
// - Missing end sentinel lights error, resets read
// - Capture check character after end sentinel
// - Check parity, repack bytes per track format
// - Parity error lights error, message still sent
// - Send header, type, sentinels, data, check
// - First message character is hex 21
// - Reader type character is hex 10
// - Bank sentinels are hex 0B and 1F
// - Up to 37 bank, 76 airline data characters
// - Check character parity covers itself only
// - Wait load, lock keyboard, next load sends MSB
// - Remaining bits go LSB first per clock
// - Repeat per byte, then release keyboard lock
// - Drive active-low reader active and bank format
// - Error lamp two seconds on any failure
module mag_stripe_card_reader_link #(
  parameter int        TW         = 24,
  parameter int        DEPTH      = 80,
  parameter [TW-1:0]   TIMEOUT    = 24'h80_0000,
  parameter [TW-1:0]   CELL_MIN   = 24'h00_0010,
  parameter [TW-1:0]   CELL_MAX   = 24'h7f_ffff,
  parameter int        ERR_CYCLES = `ERR_CYC
) (
  input  logic            clock,
  input  logic            nrst,
  input  mag_pkg::wb_req_t wb_i,
  output logic [31:0]     wb_dat_o,
  output logic            wb_ack_o,
  input  logic [2:0]      head_sel_n,
  input  logic            stripe_in,
  input  logic            kbd_load,
  input  logic            kbd_clock,
  output logic            kbd_inhibit,
  output logic            kbd_data,
  output logic            reader_active_n,
  output logic            bank_format_n,
  output logic            error_led,
  output logic            busy_led
);
  import mag_pkg::*;

  // ****************************************
  // Pin synchronisers and edge finders
  // ****************************************
  logic [5:0] raw_w;                  // Heads, stripe, load, clock
  logic [5:0] s1_reg;                 // First stage, read by s2 only
  logic [5:0] s2_reg;                 // Safe level
  logic [5:0] s3_reg;                 // Delayed copy for edges
  assign raw_w = {head_sel_n, stripe_in, kbd_load, kbd_clock};

  // Two flops before use, a third for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= `SYNC_RST;
      s2_reg <= `SYNC_RST;
      s3_reg <= `SYNC_RST;
    end else begin
      s1_reg <= raw_w;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  wire [2:0] head_w     = s2_reg[5:3];
  wire       stripe_evt = s2_reg[2] ^ s3_reg[2];
  wire       load_rise  = s2_reg[1] & ~s3_reg[1];
  wire       kclk_rise  = s2_reg[0] & ~s3_reg[0];
  wire       any_head   = (head_w != 3'b111);
  wire       air_sel    = ~head_w[1];

  // ****************************************
  // State and storage
  // ****************************************
  rd_state_t  st_reg;                 // Sequencer state
  logic       air_reg;                // Airline format latched per card
  logic [4:0] edge_reg;               // Transitions skipped so far
  logic [3:0] zc_reg;                 // Run of zero bits seen
  logic [6:0] win_reg;                // Bit window, newest at top
  logic [2:0] bitc_reg;               // Bit within character
  logic [6:0] wr_reg;                 // Characters stored
  logic [6:0] chk_reg;                // Parity check index
  logic [6:0] tx_reg;                 // Message byte index
  logic [2:0] kc_reg;                 // Keyboard clocks in byte
  logic       serial_reg;             // Line feeding the output flop
  logic       kdata_reg;              // Output flop
  logic       perr_reg;               // Sticky parity error
  logic [31:0] err_tmr_reg;           // Error lamp countdown
  logic       en_reg;                 // Reader enable
  logic       ack_reg;                // Bus acknowledge
  logic [31:0] rdat_reg;              // Bus read data
  logic       busy_reg;               // Busy lamp
  logic       act_n_reg;              // Reader active, low true
  logic       bank_n_reg;             // Bank format, low true
  logic [6:0] mem_reg [0:DEPTH-1];    // Character store

  // ****************************************
  // Biphase decoder
  // ****************************************
  logic [TW-1:0] tmr_reg;             // Cycles since last transition
  logic [TW-1:0] cell_reg;            // Cell length estimate
  logic [TW-1:0] half_reg;            // First half of a one cell
  logic          halfp_reg;           // Mid-cell transition pending

  wire [TW+1:0] tmr4_w  = {tmr_reg, 2'b00};
  wire [TW+1:0] cell3_w = {2'b00, cell_reg} + {1'b0, cell_reg, 1'b0};
  wire          short_w = (tmr4_w < cell3_w);
  wire [TW:0]   sum_w   = {1'b0, half_reg} + {1'b0, tmr_reg};
  wire [TW-1:0] cell1_w = sum_w[TW] ? '1 : sum_w[TW-1:0];
  wire decoding = (st_reg == ST_HUNT) || (st_reg == ST_STORE) || (st_reg == ST_LRC);
  wire reading  = decoding || (st_reg == ST_SKIP);
  wire bit_vld  = decoding & stripe_evt & ~(short_w & ~halfp_reg);
  wire bit_val  = short_w;

  // Timer saturates so a stalled card still trips the timeout
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tmr_reg <= '0;
    end else if (stripe_evt) begin
      tmr_reg <= '0;
    end else if (tmr_reg != '1) begin
      tmr_reg <= tmr_reg + 1'b1;
    end
  end

  // Cell estimate follows the card at every boundary
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cell_reg  <= '0;
      half_reg  <= '0;
      halfp_reg <= 1'b0;
    end else if (stripe_evt && st_reg == ST_SKIP) begin
      cell_reg  <= tmr_reg;
      halfp_reg <= 1'b0;
    end else if (stripe_evt && decoding) begin
      if (short_w && !halfp_reg) begin
        half_reg  <= tmr_reg;
        halfp_reg <= 1'b1;
      end else if (short_w) begin
        cell_reg  <= cell1_w;
        halfp_reg <= 1'b0;
      end else begin
        cell_reg  <= tmr_reg;
        halfp_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Character framing and decode conditions
  // ****************************************
  wire [6:0] win_next = {bit_val, win_reg[6:1]};
  wire [6:0] char_w   = air_reg ? win_next : {2'b00, win_next[6:2]};
  wire [2:0] last_bit = air_reg ? `AIR_LAST : `BANK_LAST;
  wire [6:0] ss_w     = air_reg ? `AIR_SS : `BANK_SS;
  wire [6:0] es_w     = air_reg ? `AIR_ES : `BANK_ES;
  wire [6:0] maxd_w   = air_reg ? `AIR_MAX : `BANK_MAX;
  wire       char_done = bit_vld && (bitc_reg == last_bit);
  wire       hunt_hit = (st_reg == ST_HUNT) && bit_vld && (zc_reg == `ZERO_RUN)
                        && (char_w == ss_w);
  wire       speed_bad = (cell_reg < CELL_MIN) || (cell_reg > CELL_MAX);
  wire       timeout_w = reading && (tmr_reg == TIMEOUT);
  wire       overflow = (st_reg == ST_STORE) && char_done && (char_w != es_w)
                        && (wr_reg == maxd_w + 7'd1);
  wire       fail_w   = timeout_w || overflow || (hunt_hit && speed_bad);
  wire       start_w  = (st_reg == ST_IDLE) && stripe_evt && en_reg && any_head
                        && (err_tmr_reg == 32'h0000_0000);
  wire [6:0] chk_char = mem_reg[chk_reg];
  wire       par_bad  = (st_reg == ST_CHECK) && ~^chk_char;

  // ****************************************
  // Message byte selection
  // ****************************************
  wire [6:0] tx_ofs  = tx_reg - 7'd2;
  wire [6:0] tx_char = mem_reg[tx_ofs];
  wire [7:0] bank_b  = {3'b000, tx_char[4], tx_char[3:0]};
  wire [7:0] air_b   = {1'b0, tx_char[5:4], tx_char[6], tx_char[3:0]};
  wire [7:0] cur_byte = (tx_reg == 7'd0) ? `SOD_CHAR :
                        (tx_reg == 7'd1) ? `TYPE_CHAR :
                        (air_reg ? air_b : bank_b);
  wire       tx_last = (tx_reg == wr_reg + 7'd1);

  // ****************************************
  // Reader sequencer
  // ****************************************
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_reg     <= ST_IDLE;
      air_reg    <= 1'b0;
      edge_reg   <= '0;
      zc_reg     <= '0;
      win_reg    <= '0;
      bitc_reg   <= '0;
      wr_reg     <= '0;
      chk_reg    <= '0;
      tx_reg     <= '0;
      kc_reg     <= '0;
      serial_reg <= 1'b0;
    end else if (fail_w) begin
      st_reg <= ST_IDLE;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (start_w) begin
            st_reg   <= ST_SKIP;
            air_reg  <= air_sel;
            edge_reg <= 5'd1;
          end
        end
        ST_SKIP: begin
          if (stripe_evt) begin
            edge_reg <= edge_reg + 5'd1;
            // Sixteenth transition ends the settling run
            if (edge_reg == `SKIP_EDGES - 5'd1) begin
              st_reg  <= ST_HUNT;
              zc_reg  <= '0;
              win_reg <= '1;
            end
          end
        end
        ST_HUNT: begin
          if (bit_vld) begin
            win_reg <= win_next;
            if (hunt_hit) begin
              st_reg     <= ST_STORE;
              mem_reg[0] <= char_w;
              wr_reg     <= 7'd1;
              bitc_reg   <= '0;
            end else if (!bit_val && zc_reg != `ZERO_RUN) begin
              zc_reg <= zc_reg + 4'd1;
            end else if (bit_val && zc_reg != `ZERO_RUN) begin
              zc_reg <= '0;
            end
          end
        end
        ST_STORE, ST_LRC: begin
          if (bit_vld) begin
            win_reg  <= win_next;
            bitc_reg <= char_done ? 3'd0 : bitc_reg + 3'd1;
          end
          if (char_done) begin
            mem_reg[wr_reg] <= char_w;
            wr_reg <= wr_reg + 7'd1;
            if (st_reg == ST_LRC) begin
              st_reg  <= ST_CHECK;
              chk_reg <= '0;
            end else if (char_w == es_w) begin
              st_reg <= ST_LRC;
            end
          end
        end
        ST_CHECK: begin
          // One stored character checked per cycle
          chk_reg <= chk_reg + 7'd1;
          if (chk_reg == wr_reg - 7'd1) begin
            st_reg <= ST_WAIT;
            tx_reg <= '0;
          end
        end
        ST_WAIT: begin
          if (load_rise) begin
            st_reg <= ST_LOCK;
          end
        end
        ST_LOCK: begin
          if (load_rise) begin
            st_reg     <= ST_SHIFT;
            serial_reg <= cur_byte[7];
            kc_reg     <= '0;
          end
        end
        ST_SHIFT: begin
          if (kclk_rise) begin
            kc_reg     <= kc_reg + 3'd1;
            serial_reg <= cur_byte[kc_reg];
            // Eighth clock has taken bit six; byte is out
            if (kc_reg == 3'd7) begin
              serial_reg <= serial_reg;
              if (tx_last) begin
                st_reg <= ST_IDLE;
              end else begin
                st_reg <= ST_LOCK;
                tx_reg <= tx_reg + 7'd1;
              end
            end
          end
        end
      endcase
    end
  end

  // ****************************************
  // Keyboard line flop and status pins
  // ****************************************
  // Line flop moves only on the host's clock edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      kdata_reg <= 1'b0;
    end else if (kclk_rise) begin
      kdata_reg <= serial_reg;
    end
  end

  // Lamps and low-true host signals
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_reg   <= 1'b0;
      act_n_reg  <= 1'b1;
      bank_n_reg <= 1'b1;
    end else begin
      busy_reg   <= (st_reg != ST_IDLE);
      act_n_reg  <= (st_reg == ST_IDLE);
      bank_n_reg <= ~(any_head && !air_sel);
    end
  end

  // Lock covers the whole byte sequence, not the first wait
  assign kbd_inhibit     = (st_reg == ST_LOCK) || (st_reg == ST_SHIFT);
  assign kbd_data        = kdata_reg;
  assign busy_led        = busy_reg;
  assign reader_active_n = act_n_reg;
  assign bank_format_n   = bank_n_reg;
  assign error_led       = (err_tmr_reg != 32'h0000_0000);

  // ****************************************
  // Wishbone slave
  // ****************************************
  wire req_w  = wb_i.cyc & wb_i.stb;
  wire wr_en  = req_w & ack_reg & wb_i.we & wb_i.sel[0];
  wire ctrl_w = wr_en && (wb_i.adr == `CTRL_OFS);
  wire stat_w = wr_en && (wb_i.adr == `STAT_OFS);
  wire clr_w  = ctrl_w && wb_i.dat[`CTRL_CLR_BIT];
  wire [31:0] stat_v = {9'h000, wr_reg, 11'h000, kbd_inhibit, air_reg,
                        perr_reg, error_led, busy_reg};
  wire [31:0] cell_v = {{(32 - TW){1'b0}}, cell_reg};
  wire [31:0] rd_mux = (wb_i.adr == `CTRL_OFS) ? {31'h0000_0000, en_reg} :
                       (wb_i.adr == `STAT_OFS) ? stat_v :
                       (wb_i.adr == `CELL_OFS) ? cell_v : 32'h0000_0000;

  // Ack one cycle after the strobe; write lands at the ack edge
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_reg  <= 1'b0;
      rdat_reg <= '0;
      en_reg   <= `CTRL_RST;
    end else begin
      ack_reg <= req_w & ~ack_reg;
      if (req_w && !ack_reg) begin
        rdat_reg <= rd_mux;
      end
      if (ctrl_w) begin
        en_reg <= wb_i.dat[`CTRL_EN_BIT];
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;

  // ****************************************
  // Error lamp and sticky parity flag
  // ****************************************
  // A new failure wins over a software clear in the same cycle
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      err_tmr_reg <= '0;
      perr_reg    <= 1'b0;
    end else begin
      if (fail_w || par_bad) begin
        err_tmr_reg <= 32'(ERR_CYCLES);
      end else if (clr_w) begin
        err_tmr_reg <= '0;
      end else if (error_led) begin
        err_tmr_reg <= err_tmr_reg - 32'h0000_0001;
      end
      if (par_bad) begin
        perr_reg <= 1'b1;
      end else if (stat_w && wb_i.dat[`STAT_PE_BIT]) begin
        perr_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_load_lock;
    (st_reg == ST_WAIT) && load_rise ##1 (st_reg == ST_LOCK);
  endsequence
  sequence s_msb_out;
    load_rise && (st_reg == ST_LOCK);
  endsequence

  a_lock_after_load: assert property (s_load_lock |-> kbd_inhibit)
    else $error("keyboard not locked after load pulse");
  a_msb_first: assert property (s_msb_out |=> serial_reg == $past(cur_byte[7]))
    else $error("first bit on line is not the msb");
  a_lsb_next: assert property ((st_reg == ST_SHIFT && kclk_rise && kc_reg == 3'd0)
      |=> serial_reg == $past(cur_byte[0]))
    else $error("lsb does not follow msb");
  a_flop_capture: assert property (kclk_rise |=> kdata_reg == $past(serial_reg))
    else $error("line flop missed keyboard clock");
  a_sod_header: assert property ((st_reg == ST_LOCK && tx_reg == 7'd0)
      |-> cur_byte == 8'h21)
    else $error("message does not open with start of data");
  a_type_code: assert property ((st_reg == ST_LOCK && tx_reg == 7'd1)
      |-> cur_byte == 8'h10)
    else $error("reader type character wrong");
  // Lamps are registered, so busy and active drop one cycle after the lock
  a_release_end: assert property ((st_reg == ST_SHIFT && kclk_rise && kc_reg == 3'd7
      && tx_last) |=> !kbd_inhibit ##1 !busy_reg && reader_active_n)
    else $error("keyboard lock not released after last byte");
  a_timeout_reset: assert property (timeout_w |=> st_reg == ST_IDLE && error_led)
    else $error("stalled read not discarded with error");
  a_parity_flag: assert property (par_bad |=> perr_reg && error_led
      ##1 st_reg != ST_IDLE)
    else $error("parity error not flagged or message dropped");
  // Threshold worked out here on its own, not through the decoder's wires
  a_short_is_one: assert property ((decoding && stripe_evt && halfp_reg
      && ({2'b00, tmr_reg} << 2) < ({2'b00, cell_reg} * 26'd3)) |-> bit_vld && bit_val)
    else $error("short interval not decoded as one");
  a_skip_count: assert property ((st_reg == ST_SKIP && stripe_evt && edge_reg == 5'd15)
      |=> st_reg == ST_HUNT || st_reg == ST_IDLE)
    else $error("hunt not entered after sixteen transitions");
endmodule : mag_stripe_card_reader_link
